// ### verilog/usb_in_endpoint_control.sv
/*
 * in-direction control of the second endpoint: registers, packet fifo,
 * token answers, toggle and interrupt pulse.
 * assumes the serial engine on the same clock gives one-cycle token/sof/ack/timeout pulses.
 */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module usb_in_endpoint_control
	import usb_in_ep_pkg::*;
#(
	parameter int FIFO_DEPTH = 64
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic [6:0] ep0_count,
	input wire logic in_token,
	input wire logic sof_seen,
	input wire logic host_ack,
	input wire logic host_timeout,
	output logic tx_start,
	output logic [1:0] tx_kind,
	output logic tx_toggle,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	output logic in_ep_irq,
	output logic [7:0] out_ctrl_low_reg,
	output logic [7:0] out_ctrl_high_reg
);

	localparam int AW = $clog2(FIFO_DEPTH);
	localparam logic [AW:0] DEPTH_CNT = (AW+1)'(FIFO_DEPTH);

	// ==========================================================
	// state
	ep_state_t state;
	logic [7:0] mem [FIFO_DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic [AW:0] start_ptr;
	logic [AW:0] pending_len;
	logic [AW:0] remain;
	logic [AW:0] len_q [2];
	logic [1:0] pkt_count;
	logic [1:0] held_cnt;
	logic [3:0] ep_index;
	logic iso_update_en;
	logic send_stall;
	logic stall_sent;
	logic underrun_flag;
	logic flush_req;
	logic iso_mode;
	logic force_toggle;
	logic double_buf;
	logic data_toggle;
	logic buf_in_ready;

	// ==========================================================
	// register decode
	wire sel_ep = ep_index == EP_INDEX_SEL;
	wire wr_low = wr_en && sel_ep && addr == IN_CTRL_LOW_ADDR;
	wire wr_high = wr_en && sel_ep && addr == IN_CTRL_HIGH_ADDR;
	wire wr_outl = wr_en && sel_ep && addr == OUT_CTRL_LOW_ADDR;
	wire wr_outh = wr_en && sel_ep && addr == OUT_CTRL_HIGH_ADDR;
	wire wr_index = wr_en && addr == INDEX_ADDR;
	wire wr_cfg = wr_en && addr == FUNC_CFG_ADDR;
	wire [AW:0] used = wr_ptr - start_ptr;
	wire fifo_full = used == DEPTH_CNT;
	// a byte written into a full fifo is dropped, firmware must watch full
	wire wr_fifo = wr_en && addr == EP_FIFO_ADDR && !fifo_full;
	wire [1:0] slots = double_buf ? 2'd2 : 2'd1;
	wire commit = wr_low && wdata[TX_PACKET_READY_BIT] && pkt_count < slots;
	// ready reads one only while every slot is taken
	wire tx_packet_ready = pkt_count == slots;
	wire fifo_not_empty = pkt_count != 2'd0;
	wire [AW:0] wr_ptr_next = wr_ptr + {{AW{1'b0}}, wr_fifo};

	// ==========================================================
	// token decisions
	wire idle = state == ST_IDLE;
	wire tok = idle && in_token;
	wire sendable = pkt_count > held_cnt;
	// stall has no meaning for isochronous pipes
	wire do_stall = tok && send_stall && !iso_mode;
	wire do_data = tok && !do_stall && sendable;
	wire do_underrun = tok && !do_stall && !sendable && iso_mode;
	wire do_nak = tok && !do_stall && !sendable && !iso_mode;
	wire push = state == ST_SEND && remain != '0 && buf_in_ready;
	wire sent_last = push && remain == (AW+1)'(1);
	wire send_done = state == ST_SEND && (remain == '0 || sent_last);
	wire iso_done = send_done && iso_mode;
	wire acked = state == ST_WAIT && host_ack;
	wire missed = state == ST_WAIT && host_timeout;
	wire pop = iso_done || acked;
	wire do_flush = idle && flush_req && !tok;
	wire drop = do_flush && fifo_not_empty;
	wire retire = pop || drop;
	wire flip = force_toggle ? (iso_done || acked || missed) : acked;
	wire irq_event = pop || drop || do_stall;
	wire commit_idx = (pkt_count - {1'b0, retire}) != 2'd0;
	wire held_drop = drop && held_cnt == pkt_count;

	// ==========================================================
	// read mux
	wire [7:0] low_val = {1'b0, 1'b0, stall_sent, send_stall, flush_req,
		underrun_flag, fifo_not_empty, tx_packet_ready};
	wire [7:0] high_val = {double_buf, iso_mode, 2'b00, force_toggle, 3'b000};
	wire [7:0] rd_value =
		(addr == IN_CTRL_LOW_ADDR && sel_ep) ? low_val :
		(addr == IN_CTRL_HIGH_ADDR && sel_ep) ? high_val :
		(addr == OUT_CTRL_LOW_ADDR && sel_ep) ? out_ctrl_low_reg :
		(addr == OUT_CTRL_HIGH_ADDR && sel_ep) ? out_ctrl_high_reg :
		(addr == INDEX_ADDR) ? {4'h0, ep_index} :
		(addr == FUNC_CFG_ADDR) ? {iso_update_en, 7'h00} :
		(addr == EP0_RX_BYTE_COUNT_ADDR) ? {1'b0, ep0_count} : 8'h00;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd_en ? rd_value : 8'h00;
		end
	end

	// ==========================================================
	// control and status bits
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ep_index <= INDEX_RESET;
			iso_update_en <= 1'b0;
			send_stall <= IN_CTRL_LOW_RESET[SEND_STALL_BIT];
			iso_mode <= IN_CTRL_HIGH_RESET[ISO_SELECT_BIT];
			force_toggle <= IN_CTRL_HIGH_RESET[FORCE_TOGGLE_BIT];
			double_buf <= IN_CTRL_HIGH_RESET[DOUBLE_BUF_BIT];
			out_ctrl_low_reg <= OUT_CTRL_RESET;
			out_ctrl_high_reg <= OUT_CTRL_RESET;
		end else begin
			if (wr_index) begin
				ep_index <= wdata[3:0];
			end
			if (wr_cfg) begin
				iso_update_en <= wdata[ISO_UPDATE_BIT];
			end
			if (wr_low) begin
				send_stall <= wdata[SEND_STALL_BIT];
			end
			if (wr_high) begin
				iso_mode <= wdata[ISO_SELECT_BIT];
				force_toggle <= wdata[FORCE_TOGGLE_BIT];
				double_buf <= wdata[DOUBLE_BUF_BIT];
			end
			if (wr_outl) begin
				out_ctrl_low_reg <= wdata;
			end
			if (wr_outh) begin
				out_ctrl_high_reg <= wdata;
			end
		end
	end

	// hardware set beats a firmware clear in the same cycle for stall-sent and underrun; a clear-toggle write beats a toggle flip
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stall_sent <= IN_CTRL_LOW_RESET[STALL_SENT_BIT];
			underrun_flag <= IN_CTRL_LOW_RESET[UNDERRUN_BIT];
			flush_req <= IN_CTRL_LOW_RESET[FLUSH_BIT];
			data_toggle <= 1'b0;
		end else begin
			stall_sent <= do_stall || (stall_sent && !(wr_low && !wdata[STALL_SENT_BIT]));
			underrun_flag <= do_underrun ||
				(underrun_flag && !(wr_low && !wdata[UNDERRUN_BIT]));
			flush_req <= (wr_low && wdata[FLUSH_BIT]) || (flush_req && !do_flush);
			if (wr_low && wdata[CLEAR_TOGGLE_BIT]) begin
				data_toggle <= 1'b0;
			end else if (flip) begin
				data_toggle <= ~data_toggle;
			end
		end
	end

	// ==========================================================
	// packet queue
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			start_ptr <= '0;
			pending_len <= '0;
			pkt_count <= 2'd0;
			held_cnt <= 2'd0;
			len_q[0] <= '0;
			len_q[1] <= '0;
		end else begin
			wr_ptr <= wr_ptr_next;
			if (do_stall) begin
				// a stall empties the whole fifo, queued and partial
				start_ptr <= wr_ptr_next;
				pending_len <= '0;
				pkt_count <= 2'd0;
				held_cnt <= 2'd0;
			end else begin
				if (retire) begin
					start_ptr <= start_ptr + len_q[0];
					len_q[0] <= len_q[1];
				end
				if (commit) begin
					len_q[commit_idx] <= pending_len;
					pending_len <= '0;
				end else if (wr_fifo) begin
					pending_len <= pending_len + (AW+1)'(1);
				end
				pkt_count <= pkt_count + {1'b0, commit} - {1'b0, retire};
				if (sof_seen) begin
					held_cnt <= {1'b0, commit && iso_update_en};
				end else begin
					held_cnt <= held_cnt + {1'b0, commit && iso_update_en} - {1'b0, held_drop};
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (wr_fifo) begin
			mem[wr_ptr[AW-1:0]] <= wdata;
		end
	end

	// ==========================================================
	// answer header and interrupt pulse
	// kind and toggle latch only on an accepted token, so they stand until the next one
	wire [1:0] next_kind = do_stall ? KIND_STALL : (do_nak ? KIND_NAK : KIND_DATA);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_start <= 1'b0;
			tx_kind <= KIND_DATA;
			tx_toggle <= 1'b0;
			in_ep_irq <= 1'b0;
		end else begin
			tx_start <= tok;
			in_ep_irq <= irq_event;
			if (tok) begin
				tx_toggle <= data_toggle;
				tx_kind <= next_kind;
			end
		end
	end

	// ==========================================================
	// answer engine
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			rd_ptr <= '0;
			remain <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (do_data) begin
						state <= ST_SEND;
						rd_ptr <= start_ptr;
						remain <= len_q[0];
					end
				end
				ST_SEND: begin
					if (push) begin
						rd_ptr <= rd_ptr + (AW+1)'(1);
						remain <= remain - (AW+1)'(1);
					end
					if (send_done) begin
						// isochronous pipes expect no handshake
						state <= iso_mode ? ST_IDLE : ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (acked || missed) begin
						state <= ST_IDLE;
						// a lost handshake leaves the packet queued for retry
						rd_ptr <= start_ptr;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// output buffer: receiver stall holds the engine, no byte is lost
	two_entry_buffer #(
		.WIDTH(9)
	) u_out_buf (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(push),
		.in_ready(buf_in_ready),
		.in_data({sent_last, mem[rd_ptr[AW-1:0]]}),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data({tx_last, tx_data})
	);

endmodule : usb_in_endpoint_control

// ### verilog/usb_in_ep_pkg.sv
/*
 * constants, encodings and state type for the second endpoint's IN control logic.
 * assumes a byte-wide register port on the same clock as the packet engine.
 */
// Overview of operation
// - in/out control registers appear only while the index register selects this endpoint
// - writing one to high control bit 6 selects isochronous mode
// - with that bit zero, bulk and interrupt traffic share one identical path
// - interrupt on packet sent, flush of a non-empty fifo, or stall sent
// - an in token with a packet ready sends it, clears ready, interrupts
// - packet-ready with no bytes loaded sends a zero-length packet
// - while send-stall is one every in token outside isochronous mode gets a stall
// - each stall sets stall-sent and interrupts; firmware clears stall-sent
// - ready clears when a slot frees; double buffering clears it at once, silently
// - no interrupt for a nak or an underrun, only for sent data, a stall or a flush
// - force-toggle set flips the data toggle after every packet except an underrun zero-length, any handshake
// - force-toggle clear flips the data toggle only on host ack
// - isochronous token with nothing ready sends zero-length and sets underrun
// - with iso update on, new packets wait for the next start of frame
// - clear-toggle write of one zeroes the data toggle; reads as zero
// - flush write of one discards the next queued packet
package usb_in_ep_pkg;

	// ==========================================================
	// register offsets
	localparam logic [7:0] FUNC_CFG_ADDR = 8'h01;
	localparam logic [7:0] INDEX_ADDR = 8'h0e;
	localparam logic [7:0] IN_CTRL_LOW_ADDR = 8'h11;
	localparam logic [7:0] IN_CTRL_HIGH_ADDR = 8'h12;
	localparam logic [7:0] OUT_CTRL_LOW_ADDR = 8'h14;
	localparam logic [7:0] OUT_CTRL_HIGH_ADDR = 8'h15;
	localparam logic [7:0] EP0_RX_BYTE_COUNT_ADDR = 8'h16;
	localparam logic [7:0] EP_FIFO_ADDR = 8'h21;
	localparam logic [3:0] EP_INDEX_SEL = 4'h1;

	// ==========================================================
	// field positions
	localparam int TX_PACKET_READY_BIT = 0;
	localparam int FIFO_NOT_EMPTY_BIT = 1;
	localparam int UNDERRUN_BIT = 2;
	localparam int FLUSH_BIT = 3;
	localparam int SEND_STALL_BIT = 4;
	localparam int STALL_SENT_BIT = 5;
	localparam int CLEAR_TOGGLE_BIT = 6;
	localparam int FORCE_TOGGLE_BIT = 3;
	localparam int ISO_SELECT_BIT = 6;
	localparam int DOUBLE_BUF_BIT = 7;
	localparam int ISO_UPDATE_BIT = 7;

	// ==========================================================
	// reset values
	localparam logic [7:0] IN_CTRL_LOW_RESET = 8'h00;
	localparam logic [7:0] IN_CTRL_HIGH_RESET = 8'h00;
	localparam logic [7:0] OUT_CTRL_RESET = 8'h00;
	localparam logic [3:0] INDEX_RESET = 4'h0;
	localparam logic [7:0] EP0_RX_BYTE_COUNT_RESET = 8'h00;

	// ==========================================================
	// answer kinds towards the serial engine
	localparam logic [1:0] KIND_DATA = 2'h0;
	localparam logic [1:0] KIND_NAK = 2'h1;
	localparam logic [1:0] KIND_STALL = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_WAIT = 3'b100
	} ep_state_t;

endpackage : usb_in_ep_pkg

// ### verilog/two_entry_buffer.sv
/*
 * two-entry buffer with valid/ready on both sides.
 * assumes source and sink share clk; entries held in flip-flops.
 */
`timescale 1ns/1ps
module two_entry_buffer #(
	parameter int WIDTH = 9
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	logic [WIDTH-1:0] entry [2];
	logic wr_sel;
	logic rd_sel;
	logic [1:0] fill;
	wire do_in = in_valid && in_ready;
	wire do_out = out_valid && out_ready;

	// ==========================================================
	// handshakes
	assign in_ready = fill != 2'd2;
	assign out_valid = fill != 2'd0;
	assign out_data = entry[rd_sel];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_sel <= 1'b0;
			rd_sel <= 1'b0;
			fill <= 2'd0;
		end else begin
			if (do_in) begin
				wr_sel <= ~wr_sel;
			end
			if (do_out) begin
				rd_sel <= ~rd_sel;
			end
			fill <= fill + {1'b0, do_in} - {1'b0, do_out};
		end
	end

	// data flops need no reset; valid guards them
	always_ff @(posedge clk) begin
		if (do_in) begin
			entry[wr_sel] <= in_data;
		end
	end

endmodule : two_entry_buffer

// ### verif/usb_in_ep_monitor.sv
/* port checker for the in endpoint control.
 assumes it is bound onto usb_in_endpoint_control. */
`timescale 1ns/1ps
module usb_in_ep_monitor
	import usb_in_ep_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic rd_en,
	input wire logic [7:0] rdata,
	input wire logic in_token,
	input wire logic tx_start,
	input wire logic [1:0] tx_kind,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic tx_ready,
	input wire logic in_ep_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// properties
	property p_start_cause;
		tx_start |-> $past(in_token);
	endproperty
	a_start_cause: assert property (p_start_cause) else $error("answer without token");
	property p_irq_pulse;
		in_ep_irq |=> !in_ep_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
	property p_rdata_idle;
		!rd_en |=> rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
	property p_stall_irq;
		tx_start && tx_kind == KIND_STALL |-> ##[0:2] in_ep_irq;
	endproperty
	a_stall_irq: assert property (p_stall_irq) else $error("stall without irq");
	property p_stall_no_data;
		tx_start && tx_kind != KIND_DATA |=> !tx_valid [*3];
	endproperty
	a_stall_no_data: assert property (p_stall_no_data) else $error("bytes after stall");
	property p_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
	endproperty
	a_hold: assert property (p_hold) else $error("byte lost under stall");
	property p_kind_legal;
		tx_start |-> tx_kind != 2'h3;
	endproperty
	a_kind_legal: assert property (p_kind_legal) else $error("bad answer kind");
	property p_last_ends;
		tx_valid && tx_ready && tx_last |=> !tx_valid;
	endproperty
	a_last_ends: assert property (p_last_ends) else $error("bytes after last");
endmodule : usb_in_ep_monitor

bind usb_in_endpoint_control usb_in_ep_monitor u_usb_in_ep_monitor (.clk, .sys_rst, .rd_en,
	.rdata, .in_token, .tx_start, .tx_kind, .tx_valid, .tx_data, .tx_last, .tx_ready,
	.in_ep_irq);

// ### verif/usb_host_model.sv
/* host side model: issues in tokens, takes bytes, returns ack or timeout.
 assumes go and mode come from the bench, one token per go pulse. */
`timescale 1ns/1ps
module usb_host_model
	import usb_in_ep_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic go,
	input wire logic [1:0] mode,
	input wire logic slow,
	input wire logic tx_start,
	input wire logic [1:0] tx_kind,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic in_token,
	output logic host_ack,
	output logic host_timeout,
	output logic tx_ready
);
	logic [7:0] got[$];
	logic [2:0] hs;
	// ==========================================================
	// handshake a few cycles after the last byte; mode 0 answers nothing (iso)
	always @(posedge clk) begin
		in_token <= go;
		host_ack <= 1'b0;
		host_timeout <= 1'b0;
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (sys_rst) begin
			tx_ready <= 1'b0;
			hs <= 3'h0;
		end else if (tx_start && tx_kind == KIND_DATA) begin
			hs <= 3'h6;
		end else if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
			hs <= 3'h4;
		end else if (hs == 3'h1) begin
			host_ack <= mode == 2'h1;
			host_timeout <= mode == 2'h2;
			hs <= 3'h0;
		end else if (hs != 3'h0) begin
			hs <= hs - 3'h1;
		end
	end
endmodule : usb_host_model

// ### verif/usb_in_endpoint_control_tb_top.sv
/* testbench top for the in endpoint control.
 assumes the package, design, host model and checker are compiled first. */
`timescale 1ns/1ps
module usb_in_endpoint_control_tb_top
	import usb_in_ep_pkg::*;
;
	logic clk, sys_rst, wr_en, rd_en, go, sof_seen, slow, in_token, host_ack, host_timeout;
	logic tx_start, tx_toggle, tx_valid, tx_last, tx_ready, in_ep_irq, s_tog;
	logic [7:0] addr, wdata, rdata, tx_data, ocl, och;
	logic [1:0] tx_kind, mode, s_kind;
	int mismatches = 0, n_tests = 0, n_irq = 0, n_start = 0, c;
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (in_ep_irq === 1'b1) n_irq <= n_irq + 1;
		if (tx_start === 1'b1) begin
			n_start <= n_start + 1;
			s_kind <= tx_kind;
			s_tog <= tx_toggle;
		end
	end
	usb_in_endpoint_control #(.FIFO_DEPTH(8)) u_usb_in_endpoint_control (.clk, .sys_rst, .addr,
		.wdata, .wr_en, .rd_en, .rdata, .ep0_count(7'h2b), .in_token, .sof_seen, .host_ack,
		.host_timeout, .tx_start, .tx_kind, .tx_toggle, .tx_valid, .tx_data, .tx_last,
		.tx_ready, .in_ep_irq, .out_ctrl_low_reg(ocl), .out_ctrl_high_reg(och));
	usb_host_model u_usb_host_model (.clk, .sys_rst, .go, .mode, .slow, .tx_start, .tx_kind,
		.tx_valid, .tx_data, .tx_last, .in_token, .host_ack, .host_timeout, .tx_ready);
	// ==========================================================
	// shared tasks
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 chk(rdata, e);
		@(posedge clk);
	endtask : rc
	// token, answer kind and toggle, then bytes seen so far once the host is done
	task automatic tok(input logic [1:0] m, input logic [1:0] k, input logic t, input int n);
		int s0;
		s0 = n_start;
		mode <= m;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (int i = 0; i < 20 && n_start == s0; i++) @(posedge clk);
		chk(8'(n_start - s0), 8'h01);
		chk({6'h0, s_kind}, {6'h0, k});
		chk({7'h0, s_tog}, {7'h0, t});
		for (int i = 0; i < 60 && (u_usb_host_model.hs != 0 || tx_valid); i++) @(posedge clk);
		chk({7'h0, tx_valid || u_usb_host_model.hs != 3'h0}, 8'h00);
		repeat (3) @(posedge clk);
		chk(8'(u_usb_host_model.got.size()), 8'(n));
	endtask : tok
	// ==========================================================
	// scenarios
	task automatic t_regs;
		wr(OUT_CTRL_LOW_ADDR, 8'h5a);
		wr(INDEX_ADDR, {4'h0, EP_INDEX_SEL});
		rc(OUT_CTRL_LOW_ADDR, OUT_CTRL_RESET);
		wr(OUT_CTRL_LOW_ADDR, 8'h5a);
		rc(OUT_CTRL_LOW_ADDR, 8'h5a);
		chk(ocl, 8'h5a);
		wr(OUT_CTRL_HIGH_ADDR, 8'ha5);
		rc(OUT_CTRL_HIGH_ADDR, 8'ha5);
		chk(och, 8'ha5);
		rc(IN_CTRL_HIGH_ADDR, IN_CTRL_HIGH_RESET);
		rc(EP0_RX_BYTE_COUNT_ADDR, 8'h2b);
		rc(8'h30, 8'h00);
		$display("regs done");
	endtask : t_regs
	task automatic t_bulk;
		slow <= 1'b1;
		wr(EP_FIFO_ADDR, 8'ha5);
		wr(EP_FIFO_ADDR, 8'h3c);
		wr(IN_CTRL_LOW_ADDR, 8'h01);
		rc(IN_CTRL_LOW_ADDR, 8'h03);
		c = n_irq;
		tok(2'h1, KIND_DATA, 1'b0, 2);
		chk(8'(n_irq - c), 8'h01);
		chk(u_usb_host_model.got[0], 8'ha5);
		chk(u_usb_host_model.got[1], 8'h3c);
		rc(IN_CTRL_LOW_ADDR, 8'h00);
		slow <= 1'b0;
		wr(IN_CTRL_LOW_ADDR, 8'h41);
		rc(IN_CTRL_LOW_ADDR, 8'h03);
		tok(2'h1, KIND_DATA, 1'b0, 2);
		$display("bulk done");
	endtask : t_bulk
	task automatic t_toggle;
		wr(IN_CTRL_HIGH_ADDR, 8'h08);
		wr(EP_FIFO_ADDR, 8'h11);
		wr(IN_CTRL_LOW_ADDR, 8'h01);
		tok(2'h2, KIND_DATA, 1'b1, 3);
		tok(2'h1, KIND_DATA, 1'b0, 4);
		chk(u_usb_host_model.got[3], 8'h11);
		wr(IN_CTRL_HIGH_ADDR, 8'h00);
		wr(EP_FIFO_ADDR, 8'h22);
		wr(IN_CTRL_LOW_ADDR, 8'h01);
		tok(2'h2, KIND_DATA, 1'b1, 5);
		tok(2'h1, KIND_DATA, 1'b1, 6);
		$display("toggle done");
	endtask : t_toggle
	task automatic t_stall;
		c = n_irq;
		wr(IN_CTRL_LOW_ADDR, 8'h10);
		tok(2'h0, KIND_STALL, 1'b0, 6);
		chk(8'(n_irq - c), 8'h01);
		rc(IN_CTRL_LOW_ADDR, 8'h30);
		wr(IN_CTRL_LOW_ADDR, 8'h00);
		rc(IN_CTRL_LOW_ADDR, 8'h00);
		c = n_irq;
		tok(2'h0, KIND_NAK, 1'b0, 6);
		chk(8'(n_irq - c), 8'h00);
		$display("stall done");
	endtask : t_stall
	task automatic t_double;
		c = n_irq;
		wr(IN_CTRL_HIGH_ADDR, 8'h80);
		wr(EP_FIFO_ADDR, 8'h77);
		wr(IN_CTRL_LOW_ADDR, 8'h01);
		rc(IN_CTRL_LOW_ADDR, 8'h02);
		chk(8'(n_irq - c), 8'h00);
		wr(IN_CTRL_LOW_ADDR, 8'h08);
		repeat (3) @(posedge clk);
		chk(8'(n_irq - c), 8'h01);
		rc(IN_CTRL_LOW_ADDR, 8'h00);
		$display("double done");
	endtask : t_double
	task automatic t_iso;
		wr(IN_CTRL_HIGH_ADDR, 8'hc0);
		tok(2'h0, KIND_DATA, 1'b0, 6);
		rc(IN_CTRL_LOW_ADDR, 8'h04);
		wr(IN_CTRL_LOW_ADDR, 8'h00);
		wr(FUNC_CFG_ADDR, 8'h80);
		wr(EP_FIFO_ADDR, 8'h5a);
		wr(IN_CTRL_LOW_ADDR, 8'h01);
		tok(2'h0, KIND_DATA, 1'b0, 6);
		sof_seen <= 1'b1;
		@(posedge clk);
		sof_seen <= 1'b0;
		tok(2'h0, KIND_DATA, 1'b0, 7);
		chk(u_usb_host_model.got[6], 8'h5a);
		$display("iso done");
	endtask : t_iso
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	// ==========================================================
	// main sequence and watchdog
	initial begin
		{sys_rst, wr_en, rd_en, go, sof_seen, slow, mode, addr, wdata} = {6'h20, 18'h0};
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs;
		t_bulk;
		t_toggle;
		t_stall;
		t_double;
		t_iso;
		end_sim;
	end
	initial begin
		#200000;
		mismatches++;
		end_sim;
	end
endmodule : usb_in_endpoint_control_tb_top
